// >>> logic/pci_cfg_pkg.sv
// constants for the target window and option configuration block
package pci_cfg_pkg;
    // register offsets: configuration space and first memory window
    localparam logic [11:0] OFS_WIN_CFG     = 12'h040;
    localparam logic [11:0] OFS_WIN_CFG_MEM = 12'h340;
    localparam logic [11:0] OFS_OPT_CFG     = 12'h048;
    localparam logic [11:0] OFS_OPT_CFG_MEM = 12'h348;
    localparam logic [11:0] OFS_WIN0_BASE   = 12'h010;
    localparam logic [11:0] OFS_WIN1_BASE   = 12'h014;
    localparam logic [11:0] OFS_CARD_INFO   = 12'h028;
    localparam logic [11:0] OFS_LAT_INT     = 12'h03C;
    localparam logic [11:0] OFS_STAT_CMD    = 12'h004;
    // reset values
    localparam logic [31:0] WIN_CFG_RESET   = 32'h0000B4A8;
    localparam logic [31:0] OPT_CFG_RESET   = 32'hC7000000;
    localparam logic [31:0] LAT_INT_RESET   = 32'h00000100;
    // window configuration fields
    localparam int WIN1_EN_BIT    = 15;
    localparam int WIN1_SIZE_LSB  = 10;
    localparam int WIN1_LOW_BIT   = 9;
    localparam int WIN0_EN_BIT    = 7;
    localparam int WIN0_SIZE_LSB  = 2;
    localparam int WIN0_LOW_BIT   = 1;
    localparam int SIZE_W         = 5;
    localparam logic [31:0] WIN_CFG_WMASK = 32'h0000FEFE;
    // option fields
    localparam int OPT_TOP_BIT    = 31;
    localparam int BE_ABORT_BIT   = 30;
    localparam int CARD_BUS_BIT   = 29;
    localparam int FAST_DIS_BIT   = 28;
    localparam int LAT_WR_BIT     = 27;
    localparam int RETRY_LSB      = 24;
    localparam int RETRY_W        = 3;
    localparam logic [31:0] OPT_CFG_WMASK = 32'h7F000000;
    // other fields
    localparam int FAST_B2B_FLAG_BIT = 23;
    localparam int BASE_TYPE_BIT     = 1;
    localparam int BASE_IO_BIT       = 0;
    localparam logic [31:0] LAT_FIELDS_MASK = 32'hFFFF0000;
    localparam logic [31:0] INT_LINE_MASK   = 32'h000000FF;
    localparam int RETRY_CNT_W = 8;
endpackage

// >>> logic/retry_limiter.sv
// hardware retry counter that turns too many retries into a bus error
`timescale 1ns/1ps
module retry_limiter
    import pci_cfg_pkg::*;
(
    input  wire logic               clk,          // pci clock
    input  wire logic               rst_n,        // sync reset, low
    input  wire logic [RETRY_W-1:0] limitExp,     // retry limit exponent
    input  wire logic               cycStart,     // new cycle attempt sequence
    input  wire logic               cycRetry,     // target asked for retry
    input  wire logic               cycDone,      // cycle completed
    output logic                    busError      // one-cycle bus error pulse
);
    logic [RETRY_CNT_W-1:0] retryCnt_ff;
    logic [RETRY_CNT_W-1:0] limitCnt;

    // two to the power of the exponent, at most 128
    assign limitCnt = RETRY_CNT_W'(1) << limitExp;

    // count retries; restart per sequence, clear on done or error
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            retryCnt_ff <= '0;
            busError    <= 1'b0;
        end else begin
            busError <= 1'b0;
            if (cycStart || cycDone) begin
                retryCnt_ff <= '0;
            end else if (cycRetry) begin
                if (retryCnt_ff >= limitCnt - RETRY_CNT_W'(1)) begin
                    busError    <= 1'b1;
                    retryCnt_ff <= '0;
                end else begin
                    retryCnt_ff <= retryCnt_ff + RETRY_CNT_W'(1);
                end
            end
        end
    end
endmodule

// >>> logic/pci_target_window_and_option_config.sv
// window and option configuration registers of the pci target
//
// How it works
// - enabled window base register is read/write and decodes pci addresses
// - disabled window base register reads all zeros
// - size field gives 2^(size+1) bytes; low base bits read fixed
// - set placement bit on memory window asks for first megabyte
// - placement bit ignored for io windows
// - placement bit mirrored into base register type bit
// - reserved bits written zero; reads here return zero, except option bit 31 which reads one
// - byte-enable option set: misaligned byte enables give target abort
// - option clear: disconnect as success, no internal cycle started
// - card-bus option gates card info pointer; clear reads zero
// - fast back-to-back flag reported only while disable bit is clear
// - latency write option makes max latency and min grant writable
// - retry up to 2^limit times then report bus error
// - option register at 0x48 config, 0x348 in first window
// - option register resets to 0xC7000000
// - window config at 0x40 / 0x340, resets to 0x0000B4A8
`timescale 1ns/1ps
module pci_target_window_and_option_config
    import pci_cfg_pkg::*;
(
    input  wire logic               clk,            // pci clock
    input  wire logic               rst_n,          // sync reset, low
    input  wire logic               regWrite,       // register write strobe
    input  wire logic               regRead,        // register read strobe
    input  wire logic               regMemSpace,    // access via first window
    input  wire logic [11:0]        regAddr,        // register byte offset
    input  wire logic [31:0]        regWdata,       // write data
    input  wire logic [1:0]         winIsIo,        // window maps to io space
    input  wire logic [31:0]        pciAddr,        // incoming pci address
    input  wire logic               slaveXfer,      // slave transfer data phase
    input  wire logic [3:0]         slaveBeN,       // byte enables, active low
    input  wire logic               cycStart,       // master cycle sequence start
    input  wire logic               cycRetry,       // master cycle got retry
    input  wire logic               cycDone,        // master cycle completed
    output logic [31:0]             regRdata,       // read data
    output logic                    regRvalid,      // read data valid pulse
    output logic [1:0]              winHit,         // address decodes to window
    output logic                    targetAbort,    // end transfer with abort
    output logic                    targetDisc,     // end with disconnect
    output logic                    internalCycle,  // start internal cycle
    output logic                    busError,       // retry limit hit
    output logic                    fastB2bCapable  // status flag copy
);
    logic [31:0] winCfg_ff;
    logic [31:0] optCfg_ff;
    logic [31:0] base_ff [2];
    logic [31:0] cardInfo_ff;
    logic [31:0] latInt_ff;
    logic [31:0] nxt_rdata;
    logic [31:0] baseRead [2];
    logic [31:0] sizeMask [2];
    logic [1:0]  winEn;
    logic        selWin;
    logic        selOpt;
    logic        beAligned;

    // address select for the two registers with two aliases
    assign selWin = (!regMemSpace && regAddr == OFS_WIN_CFG)
                 || (regMemSpace && regAddr == OFS_WIN_CFG_MEM);
    assign selOpt = (!regMemSpace && regAddr == OFS_OPT_CFG)
                 || (regMemSpace && regAddr == OFS_OPT_CFG_MEM);

    // window configuration register; reserved bits kept zero
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            winCfg_ff <= WIN_CFG_RESET;
        end else if (regWrite && selWin) begin
            winCfg_ff <= regWdata & WIN_CFG_WMASK;
        end
    end

    // option register; bit 31 reads one, other reserved bits zero
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            optCfg_ff <= OPT_CFG_RESET;
        end else if (regWrite && selOpt) begin
            optCfg_ff <= (regWdata & OPT_CFG_WMASK) | (32'h1 << OPT_TOP_BIT);
        end
    end

    assign winEn[0] = winCfg_ff[WIN0_EN_BIT];
    assign winEn[1] = winCfg_ff[WIN1_EN_BIT];

    // per-window base register, size mask and decode
    for (genvar w = 0; w < 2; w++) begin : g_win
        localparam int SLSB = (w == 0) ? WIN0_SIZE_LSB : WIN1_SIZE_LSB;
        localparam int LBIT = (w == 0) ? WIN0_LOW_BIT : WIN1_LOW_BIT;
        localparam logic [11:0] BOFS = (w == 0) ? OFS_WIN0_BASE : OFS_WIN1_BASE;
        logic [SIZE_W-1:0] sz;
        logic              lowBit;
        assign sz = winCfg_ff[SLSB +: SIZE_W];
        // bits below 2^(sz+1) are fixed; size 31 leaves no bit writable
        assign sizeMask[w] = 32'hFFFFFFFF << ({1'b0, sz} + 6'h01);
        // placement only meaningful for memory windows
        assign lowBit = winCfg_ff[LBIT] && !winIsIo[w];
        assign baseRead[w] = !winEn[w] ? 32'h0 :
            ((base_ff[w] & sizeMask[w])
             | (32'(lowBit) << BASE_TYPE_BIT)
             | (32'(winIsIo[w]) << BASE_IO_BIT));
        always_ff @(posedge clk) begin
            if (!rst_n) begin
                base_ff[w] <= '0;
            end else if (regWrite && !regMemSpace && regAddr == BOFS && winEn[w]) begin
                base_ff[w] <= regWdata & sizeMask[w];
            end
        end
        // address decode against the enabled window
        always_ff @(posedge clk) begin
            if (!rst_n) begin
                winHit[w] <= 1'b0;
            end else begin
                winHit[w] <= winEn[w]
                    && ((pciAddr & sizeMask[w]) == (base_ff[w] & sizeMask[w]));
            end
        end
    end

    // card info pointer, only live with the card-bus option
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            cardInfo_ff <= '0;
        end else if (regWrite && regAddr == OFS_CARD_INFO && optCfg_ff[CARD_BUS_BIT]) begin
            cardInfo_ff <= regWdata;
        end
    end

    // latency/grant bytes writable only with the option; line always
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            latInt_ff <= LAT_INT_RESET;
        end else if (regWrite && regAddr == OFS_LAT_INT) begin
            latInt_ff[7:0] <= regWdata[7:0];
            if (optCfg_ff[LAT_WR_BIT]) begin
                latInt_ff[31:16] <= regWdata[31:16];
            end
        end
    end

    // read mux; unmapped offsets read zero
    always_comb begin
        nxt_rdata = 32'h0;
        if (selWin) begin
            nxt_rdata = winCfg_ff;
        end else if (selOpt) begin
            nxt_rdata = optCfg_ff;
        end else if (regAddr == OFS_WIN0_BASE) begin
            nxt_rdata = baseRead[0];
        end else if (regAddr == OFS_WIN1_BASE) begin
            nxt_rdata = baseRead[1];
        end else if (regAddr == OFS_CARD_INFO) begin
            nxt_rdata = optCfg_ff[CARD_BUS_BIT] ? cardInfo_ff : 32'h0;
        end else if (regAddr == OFS_LAT_INT) begin
            nxt_rdata = latInt_ff;
        end else if (regAddr == OFS_STAT_CMD) begin
            nxt_rdata = 32'(!optCfg_ff[FAST_DIS_BIT]) << FAST_B2B_FLAG_BIT;
        end
    end

    // read data registered, one cycle after the strobe
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            regRdata  <= '0;
            regRvalid <= 1'b0;
        end else begin
            regRvalid <= regRead;
            if (regRead) begin
                regRdata <= nxt_rdata;
            end
        end
    end

    // status flag copy, cheap to route to the status logic
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            fastB2bCapable <= 1'b1;
        end else begin
            fastB2bCapable <= !optCfg_ff[FAST_DIS_BIT];
        end
    end

    // aligned means enabled lanes form one contiguous run
    always_comb begin
        case (slaveBeN)
            4'h0, 4'h1, 4'h3, 4'h7, 4'h8, 4'hC, 4'hE, 4'hF,
            4'h9, 4'hB, 4'hD: beAligned = 1'b1;
            default:          beAligned = 1'b0;
        endcase
    end

    // transfer termination by byte-enable pattern
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            targetAbort   <= 1'b0;
            targetDisc    <= 1'b0;
            internalCycle <= 1'b0;
        end else begin
            targetAbort   <= slaveXfer && !beAligned && optCfg_ff[BE_ABORT_BIT];
            targetDisc    <= slaveXfer && !beAligned && !optCfg_ff[BE_ABORT_BIT];
            internalCycle <= slaveXfer && beAligned;
        end
    end

    retry_limiter u_retry (
        .clk      (clk),
        .rst_n    (rst_n),
        .limitExp (optCfg_ff[RETRY_LSB +: RETRY_W]),
        .cycStart (cycStart),
        .cycRetry (cycRetry),
        .cycDone  (cycDone),
        .busError (busError)
    );
endmodule

// >>> tb/pci_cfg_props.sv
// assertion checker for the window and option configuration block
`timescale 1ns/1ps
module pci_cfg_props (
    input wire logic       clk,            // pci clock
    input wire logic       rst_n,          // sync reset, low
    input wire logic       regRead,        // read strobe
    input wire logic       regWrite,       // write strobe
    input wire logic       slaveXfer,      // data phase
    input wire logic [3:0] slaveBeN,       // byte enables, low
    input wire logic       cycStart,       // sequence start
    input wire logic       cycRetry,       // retry seen
    input wire logic       cycDone,        // cycle done
    input wire logic       regRvalid,      // read valid
    input wire logic       targetAbort,    // abort end
    input wire logic       targetDisc,     // disconnect end
    input wire logic       internalCycle,  // internal cycle
    input wire logic       busError,       // retry limit hit
    input wire logic       fastB2bCapable  // status flag
);
    // a hole inside the enable run is the unsupported pattern
    function automatic logic misal(input logic [3:0] beN);
        logic [3:0] e;
        e = ~beN;
        return e inside {4'h5, 4'h9, 4'hA, 4'hB, 4'hD};
    endfunction
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);
    sequence readSeq; regRead ##1 regRvalid; endsequence
    sequence badXfer; slaveXfer && misal(slaveBeN); endsequence
    sequence goodXfer; slaveXfer && !misal(slaveBeN); endsequence
    // read handshake and slave answers
    rvalid_after_read_a: assert property (regRead |-> readSeq)
        else $error("read strobe not answered");
    rvalid_needs_read_a: assert property (regRvalid |-> $past(regRead))
        else $error("read valid without read");
    xfer_misaligned_a: assert property (
        badXfer |=> (targetAbort ^ targetDisc) && !internalCycle)
        else $error("misaligned transfer answered wrongly");
    xfer_aligned_a: assert property (
        goodXfer |=> internalCycle && !targetAbort && !targetDisc)
        else $error("aligned transfer answered wrongly");
    xfer_quiet_a: assert property (
        !slaveXfer |=> !(targetAbort || targetDisc || internalCycle))
        else $error("slave answer without transfer");
    // retry limiter and flags
    buserr_cause_a: assert property (
        busError |-> $past(cycRetry) && !$past(cycStart) && !$past(cycDone))
        else $error("bus error without a counted retry");
    start_beats_retry_a: assert property ((cycStart || cycDone) |=> !busError)
        else $error("bus error despite counter clear");
    fast_flag_write_a: assert property (
        $changed(fastB2bCapable) |-> $past(regWrite) || $past(regWrite, 2))
        else $error("fast flag moved without a write");
    reset_outputs_a: assert property (
        disable iff (1'b0) !rst_n |=> !regRvalid && !busError && fastB2bCapable)
        else $error("outputs wrong after reset");
endmodule
bind pci_target_window_and_option_config pci_cfg_props u_props (.clk(clk), .rst_n(rst_n),
    .regRead(regRead), .regWrite(regWrite), .slaveXfer(slaveXfer), .slaveBeN(slaveBeN),
    .cycStart(cycStart), .cycRetry(cycRetry), .cycDone(cycDone), .regRvalid(regRvalid),
    .targetAbort(targetAbort), .targetDisc(targetDisc), .internalCycle(internalCycle),
    .busError(busError), .fastB2bCapable(fastB2bCapable));

// >>> tb/pci_master_model.sv
// behavioural pci master driving slave transfers and retry events
`timescale 1ns/1ps
module pci_master_model (
    input  wire logic   clk,        // pci clock
    output logic [31:0] pciAddr,    // bus address
    output logic        slaveXfer,  // data phase
    output logic [3:0]  slaveBeN,   // byte enables, low
    output logic        cycStart,   // sequence start
    output logic        cycRetry,   // retry answer
    output logic        cycDone     // cycle completed
);
    // idle bus: no enables asserted
    initial begin
        {pciAddr, slaveXfer, slaveBeN, cycStart, cycRetry, cycDone} = {33'h0, 4'hF, 3'h0};
    end
    // released enables show the inverse so stale values never look valid
    task automatic xfer(input logic [31:0] a, input logic [3:0] be);
        @(posedge clk) #1 {pciAddr, slaveXfer, slaveBeN} = {a, 1'b1, be};
        @(posedge clk) #1 {slaveXfer, slaveBeN} = {1'b0, ~be};
    endtask
    // optional start, then n back-to-back retries, then settle
    task automatic retry(input logic st, input int n);
        @(posedge clk) #1 cycStart = st;
        repeat (n) @(posedge clk) #1 {cycStart, cycRetry} = 2'b01;
        @(posedge clk) #1 {cycStart, cycRetry} = 2'b00;
        repeat (2) @(posedge clk);
    endtask
    task automatic done;
        @(posedge clk) #1 cycDone = 1;
        @(posedge clk) #1 cycDone = 0;
    endtask
endmodule

// >>> tb/pci_target_window_and_option_config_test.sv
// self-checking bench for the window and option configuration block
`timescale 1ns/1ps
module pci_target_window_and_option_config_test;
    import pci_cfg_pkg::*;
    logic        clk = 0, rst_n = 0, regWrite = 0, regRead = 0, regMemSpace = 0;
    logic [11:0] regAddr = 12'h000;
    logic [31:0] regWdata = 32'h0, pciAddr, regRdata;
    logic [1:0]  winIsIo = 2'b00, winHit;
    logic [3:0]  slaveBeN;
    logic        slaveXfer, cycStart, cycRetry, cycDone, regRvalid;
    logic        targetAbort, targetDisc, internalCycle, busError, fastB2bCapable;
    int          mismatches = 0, checks_done = 0, errs = 0;
    always #12.5 clk = ~clk;
    pci_target_window_and_option_config u_dut (.clk(clk), .rst_n(rst_n), .regWrite(regWrite),
        .regRead(regRead), .regMemSpace(regMemSpace), .regAddr(regAddr), .regWdata(regWdata),
        .winIsIo(winIsIo), .pciAddr(pciAddr), .slaveXfer(slaveXfer), .slaveBeN(slaveBeN),
        .cycStart(cycStart), .cycRetry(cycRetry), .cycDone(cycDone), .regRdata(regRdata),
        .regRvalid(regRvalid), .winHit(winHit), .targetAbort(targetAbort),
        .targetDisc(targetDisc), .internalCycle(internalCycle), .busError(busError),
        .fastB2bCapable(fastB2bCapable));
    pci_master_model u_host (.clk(clk), .pciAddr(pciAddr), .slaveXfer(slaveXfer),
        .slaveBeN(slaveBeN), .cycStart(cycStart), .cycRetry(cycRetry), .cycDone(cycDone));
    // bus error pulses are counted, since they stand one cycle only
    always @(posedge clk) if (busError === 1'b1) errs <= errs + 1;
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks_done++;
        if (got !== exp) begin
            mismatches++;
            $display("ERROR at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic wr(input logic mem, input logic [11:0] a, input logic [31:0] d);
        @(posedge clk) #1 {regWrite, regMemSpace, regAddr, regWdata} = {1'b1, mem, a, d};
        @(posedge clk) #1 regWrite = 0;
    endtask
    // data is taken one cycle after the strobe edge, as the walk gives
    task automatic rd(input logic mem, input logic [11:0] a, input logic [31:0] exp,
                      input logic [31:0] m = 32'hFFFFFFFF);
        @(posedge clk) #1 {regRead, regMemSpace, regAddr} = {1'b1, mem, a};
        @(posedge clk) #1 regRead = 0;
        chk(regRdata & m, exp);
    endtask
    task automatic results;
        $display("checks %0d mismatches %0d", checks_done, mismatches);
        if (mismatches == 0 && checks_done > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask
    // run is about 100 cycles; generous margin
    initial begin
        #(3000 * 25);
        mismatches++;
        results;
    end
    initial begin
        repeat (4) @(posedge clk);
        #1 rst_n = 1;
        rd(0, 12'h048, 32'hC7000000);
        rd(1, 12'h348, 32'hC7000000);
        rd(1, 12'h340, 32'h0000B4A8);
        rd(0, 12'h004, 32'h00800000, 32'h00800000);
        rd(0, 12'h100, 32'h0);
        wr(0, 12'h048, 32'h57000000);
        rd(0, 12'h048, 32'hD7000000);
        rd(0, 12'h004, 32'h0, 32'h00800000);
        chk(32'(fastB2bCapable), 32'h0);
        wr(0, 12'h028, 32'h12345678);
        rd(0, 12'h028, 32'h0);
        wr(0, 12'h048, 32'h67000000);
        wr(0, 12'h028, 32'h12345678);
        rd(0, 12'h028, 32'h12345678);
        wr(0, 12'h03C, 32'hAABB00CC);
        rd(0, 12'h03C, 32'h000001CC);
        wr(1, 12'h348, 32'h6F000000);
        wr(0, 12'h03C, 32'hAABB00CC);
        rd(0, 12'h03C, 32'hAABB01CC);
        $display("register test done");
        wr(0, 12'h010, 32'hFFFFFFFF);
        rd(0, 12'h010, 32'hFFFFF800);
        wr(0, 12'h040, 32'h000000B6);
        rd(0, 12'h040, 32'h000000B6);
        rd(0, 12'h010, 32'hFFFFC002);
        wr(0, 12'h014, 32'hFFFFFFFF);
        rd(0, 12'h014, 32'h0);
        winIsIo = 2'b01;
        rd(0, 12'h010, 32'hFFFFC001);
        u_host.xfer(32'hFFFFC123, 4'b0000);
        chk(32'(winHit), 32'h1);
        $display("window test done");
        u_host.xfer(32'h0, 4'b1010);
        chk(32'({targetAbort, targetDisc, internalCycle}), 32'h4);
        chk(32'(winHit), 32'h0);
        wr(0, 12'h048, 32'h22000000);
        u_host.xfer(32'h0, 4'b1010);
        chk(32'({targetAbort, targetDisc, internalCycle}), 32'h2);
        u_host.xfer(32'h0, 4'b0011);
        chk(32'({targetAbort, targetDisc, internalCycle}), 32'h1);
        $display("byte enable test done");
        errs = 0;
        u_host.retry(1, 8);
        chk(32'(errs), 32'h2);
        errs = 0;
        u_host.retry(1, 3);
        u_host.done();
        u_host.retry(0, 3);
        chk(32'(errs), 32'h0);
        $display("retry test done");
        results;
    end
endmodule
